// ### serial_status_flags.sv
// Notes on behaviour
// (R1) Reception done while receive full sets overrun
// (R2) Error flags clear on zero after one read
// (R3) Stop bit zero sets framing error
// (R4) Two stop bits: check first only
// (R5) Parity mismatch sets parity error
// (R6) Transmit end set: disabled, or empty last bit
// (R7) Transmit end clears with transmit empty clear
// (R8) Capture received multiproc bit; hold when disabled
// (R9) Transmitted character carries transmit multiproc bit
// (R10) Transmit empty set: disabled, or buffer moved
// (R11) Transmit empty clears by software or controller
// (R12) Good reception into buffer sets receive full
// (R13) Receive full clears by software or controller
// (R14) Receive full holds when reception disabled
// (R15) Smart card mode: bit 4 is error signal
// (R16) Low error signal sampled sets error status
// (R17) Error status clears on zero after one read
// (R18) Writing one to clearable flags is ignored
// (R19) Transmit end and received multiproc are read-only
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module serial_status_flags (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tx_load,
  input  wire logic        tx_last_bit,
  input  wire logic        rx_done,
  input  wire logic        rx_stop_first,
  input  wire logic        rx_parity_bad,
  input  wire logic        rx_mpb_in,
  input  wire logic        err_signal_low,
  input  wire logic        xfer_tx_write,
  input  wire logic        xfer_rx_read,
  output logic             tx_mpb_out,
  output logic             transmit_enable,
  output logic             receive_enable,
  output logic             smart_card_select,
  output logic             two_stop_bits,
  output logic             rx_buffer_load,
  output logic             transmit_request,
  output logic             receive_request,
  output logic             irq
);
  typedef struct packed {
    logic [3:0]                                ctl;
    logic                                      mpb_rx;
    logic                                      mpb_tx;
    logic [7:0]                                seen;
    logic [serial_status_pkg::IRQ_N-1:0]       irq_st;
    logic [serial_status_pkg::IRQ_N-1:0]       irq_en;
  } state_t;
  state_t state_q;
  state_t state_d;

  logic        wr_stb;
  logic        rd_stb;
  logic [4:0]  wr_addr;
  logic [4:0]  rd_addr;
  logic [7:0]  wr_data;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic        wr_ok;
  logic [7:0]  status;
  logic [7:0]  set_v;
  logic [7:0]  clr_v;
  logic [7:0]  rst_v;
  logic        wr_status;
  logic        rx_good;
  logic        rx_err;
  logic        sw_clr_transmit_empty_flag;
  logic [serial_status_pkg::IRQ_N-1:0] ev;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  axil_regs u_bus (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .ce            (ce),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rd_word       (rd_word),
    .rd_ok         (rd_ok),
    .wr_ok         (wr_ok),
    .wr_stb        (wr_stb),
    .rd_stb        (rd_stb),
    .wr_addr       (wr_addr),
    .rd_addr       (rd_addr),
    .wr_data       (wr_data)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign wr_status = wr_stb && (wr_addr == {1'b0, serial_status_pkg::OFS_STATUS});
  assign wr_ok = (wr_addr == {1'b0, serial_status_pkg::OFS_STATUS})
              || (wr_addr == {1'b0, serial_status_pkg::OFS_CONTROL})
              || (wr_addr == {1'b0, serial_status_pkg::OFS_IRQ_EN})
              || (wr_addr == serial_status_pkg::OFS_IRQ_CLRW);

  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    if (rd_addr == {1'b0, serial_status_pkg::OFS_STATUS}) begin
      rd_word = {24'h00_0000, status};
    end else if (rd_addr == {1'b0, serial_status_pkg::OFS_CONTROL}) begin
      rd_word = {28'h000_0000, state_q.ctl};
    end else if (rd_addr == {1'b0, serial_status_pkg::OFS_IRQ_ST}) begin
      rd_word = {28'h000_0000, state_q.irq_st};
    end else if (rd_addr == {1'b0, serial_status_pkg::OFS_IRQ_EN}) begin
      rd_word = {28'h000_0000, state_q.irq_en};
    end else if (rd_addr == serial_status_pkg::OFS_IRQ_CLRW) begin
      rd_word = 32'h0000_0000;
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign transmit_enable   = state_q.ctl[serial_status_pkg::CTL_TX_EN];
  assign receive_enable    = state_q.ctl[serial_status_pkg::CTL_RX_EN];
  assign smart_card_select = state_q.ctl[serial_status_pkg::CTL_SMART];
  assign two_stop_bits     = state_q.ctl[serial_status_pkg::CTL_TWO_STP];

  // ----------------------------------------------------------------
  // Flag events
  // ----------------------------------------------------------------
  assign rx_err  = smart_card_select ? 1'b0 : !rx_stop_first; // R3 R4
  assign rx_good = rx_done && receive_enable && !rx_err && !rx_parity_bad // R14
                && !status[serial_status_pkg::BIT_RX_FULL];
  assign rx_buffer_load = rx_good; // R12
  assign sw_clr_transmit_empty_flag = wr_status && !wr_data[serial_status_pkg::BIT_TX_EMPTY]
                    && state_q.seen[serial_status_pkg::BIT_TX_EMPTY];

  always_comb begin
    set_v = 8'h00;
    clr_v = 8'h00;
    set_v[serial_status_pkg::BIT_TX_EMPTY] = !transmit_enable || tx_load; // R10
    set_v[serial_status_pkg::BIT_RX_FULL]  = rx_good; // R12
    set_v[serial_status_pkg::BIT_OVERRUN]  = rx_done && receive_enable
                                          && status[serial_status_pkg::BIT_RX_FULL]; // R1
    set_v[serial_status_pkg::BIT_FRAMING]  = smart_card_select ? err_signal_low // R15 R16
                                           : (rx_done && receive_enable && rx_err); // R3
    set_v[serial_status_pkg::BIT_PARITY]   = rx_done && receive_enable && rx_parity_bad; // R5
    set_v[serial_status_pkg::BIT_TX_END]   = !transmit_enable
                   || (tx_last_bit && status[serial_status_pkg::BIT_TX_EMPTY]); // R6
    // Clear only as zero after a read of one; ones ignored
    for (int i = 3; i < 8; i++) begin
      clr_v[i] = wr_status && !wr_data[i] && state_q.seen[i]; // R2 R17 R18
    end
    clr_v[serial_status_pkg::BIT_TX_EMPTY] = sw_clr_transmit_empty_flag || xfer_tx_write; // R11
    clr_v[serial_status_pkg::BIT_RX_FULL]  = clr_v[serial_status_pkg::BIT_RX_FULL]
                                          || xfer_rx_read; // R13
    clr_v[serial_status_pkg::BIT_TX_END]   = sw_clr_transmit_empty_flag || xfer_tx_write; // R7 R19
  end

  // ----------------------------------------------------------------
  // Flag storage
  // ----------------------------------------------------------------
  assign rst_v = serial_status_pkg::STATUS_RST;

  genvar g;
  generate
    for (g = 2; g < 8; g++) begin : g_flag
      status_flag_bit u_flag (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .rst_val (rst_v[g]),
        .set_ev  (rst_v[g] ? (clr_v[g] && !set_v[g]) : set_v[g]),
        .clr_ev  (rst_v[g] ? set_v[g] : clr_v[g]),
        .flag    (status[g])
      );
    end
  endgenerate

  assign status[serial_status_pkg::BIT_RX_MPB] = state_q.mpb_rx;
  assign status[serial_status_pkg::BIT_TX_MPB] = state_q.mpb_tx;
  assign tx_mpb_out       = state_q.mpb_tx; // R9
  assign transmit_request = status[serial_status_pkg::BIT_TX_EMPTY];
  assign receive_request  = status[serial_status_pkg::BIT_RX_FULL];

  assign ev[serial_status_pkg::IRQ_TX_EMPTY] = set_v[serial_status_pkg::BIT_TX_EMPTY]
                                            && transmit_enable;
  assign ev[serial_status_pkg::IRQ_RX_FULL]  = set_v[serial_status_pkg::BIT_RX_FULL];
  assign ev[serial_status_pkg::IRQ_ERROR]    = |set_v[5:3];
  assign ev[serial_status_pkg::IRQ_TX_END]   = set_v[serial_status_pkg::BIT_TX_END]
                                            && transmit_enable;

  // ----------------------------------------------------------------
  // Registered state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (rx_done && receive_enable) begin
      state_d.mpb_rx = rx_mpb_in; // R8
    end
    if (rd_stb && rd_addr == {1'b0, serial_status_pkg::OFS_STATUS}) begin
      state_d.seen = status; // R2 R17
    end
    if (wr_status) begin
      state_d.mpb_tx = wr_data[serial_status_pkg::BIT_TX_MPB];
      state_d.seen   = 8'h00;
    end
    if (wr_stb && wr_addr == {1'b0, serial_status_pkg::OFS_CONTROL}) begin
      state_d.ctl = wr_data[3:0];
    end
    if (wr_stb && wr_addr == {1'b0, serial_status_pkg::OFS_IRQ_EN}) begin
      state_d.irq_en = wr_data[3:0];
    end
    if (wr_stb && wr_addr == serial_status_pkg::OFS_IRQ_CLRW) begin
      state_d.irq_st = state_q.irq_st & ~wr_data[3:0];
    end
    state_d.irq_st = state_d.irq_st | ev;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign irq = |(state_q.irq_st & state_q.irq_en);
endmodule

// ### serial_status_pkg.sv
package serial_status_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS  = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h4;
  localparam logic [3:0] OFS_IRQ_ST  = 4'h8;
  localparam logic [3:0] OFS_IRQ_EN  = 4'hc;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h0; // Second page, see OFS_IRQ_CLRW
  localparam logic [4:0] OFS_IRQ_CLRW = 5'h10;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int BIT_TX_EMPTY = 7;
  localparam int BIT_RX_FULL  = 6;
  localparam int BIT_OVERRUN  = 5;
  localparam int BIT_FRAMING  = 4;
  localparam int BIT_PARITY   = 3;
  localparam int BIT_TX_END   = 2;
  localparam int BIT_RX_MPB   = 1;
  localparam int BIT_TX_MPB   = 0;

  // ----------------------------------------------------------------
  // Control bit positions
  // ----------------------------------------------------------------
  localparam int CTL_TX_EN   = 0;
  localparam int CTL_RX_EN   = 1;
  localparam int CTL_SMART   = 2;
  localparam int CTL_TWO_STP = 3;

  // ----------------------------------------------------------------
  // Interrupt event positions
  // ----------------------------------------------------------------
  localparam int IRQ_TX_EMPTY = 0;
  localparam int IRQ_RX_FULL  = 1;
  localparam int IRQ_ERROR    = 2;
  localparam int IRQ_TX_END   = 3;
  localparam int IRQ_N        = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_RST  = 8'h84;
  localparam logic [3:0] CONTROL_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### status_flag_bit.sv
`timescale 1ns/1ps
module status_flag_bit (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic rst_val,
  input  wire logic set_ev,
  input  wire logic clr_ev,
  output logic      flag
);
  typedef struct packed {
    logic f;
  } state_t;
  state_t state_q;
  state_t state_d;

  // ----------------------------------------------------------------
  // Sticky flag, set wins over clear
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (clr_ev) begin
      state_d.f = 1'b0;
    end
    if (set_ev) begin
      state_d.f = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign flag = state_q.f ^ rst_val;
endmodule

// ### axil_regs.sv
`timescale 1ns/1ps
module axil_regs (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] rd_word,
  input  wire logic        rd_ok,
  input  wire logic        wr_ok,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic [4:0]       wr_addr,
  output logic [4:0]       rd_addr,
  output logic [7:0]       wr_data
);
  typedef struct packed {
    logic        aw_have;
    logic [4:0]  aw;
    logic        w_have;
    logic [7:0]  wd;
    logic        wlane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;
  state_t state_q;
  state_t state_d;

  // ----------------------------------------------------------------
  // Write and read channels
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    wr_stb  = 1'b0;
    rd_stb  = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      state_d.aw_have = 1'b1;
      state_d.aw      = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_d.w_have = 1'b1;
      state_d.wd     = s_axi_wdata[7:0];
      state_d.wlane  = s_axi_wstrb[0];
    end
    if (state_q.aw_have && state_q.w_have && !state_q.bvalid) begin
      wr_stb          = state_q.wlane;
      state_d.aw_have = 1'b0;
      state_d.w_have  = 1'b0;
      state_d.bvalid  = 1'b1;
      state_d.bresp   = wr_ok ? serial_status_pkg::RESP_OKAY : serial_status_pkg::RESP_SLVERR;
    end
    if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rd_stb        = 1'b1;
      state_d.rvalid = 1'b1;
      state_d.rdata = rd_word;
      state_d.rresp = rd_ok ? serial_status_pkg::RESP_OKAY : serial_status_pkg::RESP_SLVERR;
    end
    if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign s_axi_awready = ce && !state_q.aw_have;
  assign s_axi_wready  = ce && !state_q.w_have;
  assign s_axi_arready = ce && !state_q.rvalid;
  assign s_axi_bvalid  = state_q.bvalid;
  assign s_axi_bresp   = state_q.bresp;
  assign s_axi_rvalid  = state_q.rvalid;
  assign s_axi_rdata   = state_q.rdata;
  assign s_axi_rresp   = state_q.rresp;
  assign wr_addr       = state_q.aw;
  assign wr_data       = state_q.wd;
  assign rd_addr       = s_axi_araddr;
endmodule

// ### serial_status_flags_sva.sv
`timescale 1ns/1ps
module serial_status_flags_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic s_axi_wvalid,
  input wire logic tx_load,
  input wire logic rx_done,
  input wire logic rx_stop_first,
  input wire logic rx_parity_bad,
  input wire logic xfer_tx_write,
  input wire logic xfer_rx_read,
  input wire logic tx_mpb_out,
  input wire logic transmit_enable,
  input wire logic receive_enable,
  input wire logic smart_card_select,
  input wire logic rx_buffer_load,
  input wire logic transmit_request,
  input wire logic receive_request
);
  // ------------------------------------------------------------
  // Flag checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_load_sets_full: assert property (rx_buffer_load |=> receive_request)
    else $error("receive full not set by buffer load");
  chk_full_holds: assert property (
    receive_request && !xfer_rx_read && !s_axi_wvalid && !$past(s_axi_wvalid)
    |=> receive_request) else $error("receive full lost");
  chk_off_tx_empty: assert property (!transmit_enable |=> transmit_request)
    else $error("transmit empty low while disabled");
  chk_load_tx_empty: assert property (tx_load |=> transmit_request)
    else $error("transmit empty not set by load");
  chk_ctrl_tx_clear: assert property (
    xfer_tx_write && !tx_load && transmit_enable |=> !transmit_request)
    else $error("transmit empty not cleared by controller");
  chk_ctrl_rx_clear: assert property (xfer_rx_read && !rx_buffer_load |=> !receive_request)
    else $error("receive full not cleared by controller");
  chk_mpb_stable: assert property (
    !s_axi_wvalid && !$past(s_axi_wvalid) |=> $stable(tx_mpb_out))
    else $error("transmit multiproc bit changed without write");
  chk_load_cause: assert property (
    rx_buffer_load |-> rx_done && receive_enable && !receive_request && !rx_parity_bad)
    else $error("buffer load without good reception");
  chk_good_loads: assert property (
    rx_done && receive_enable && !receive_request && !rx_parity_bad
    && (rx_stop_first || smart_card_select) |-> rx_buffer_load)
    else $error("good reception not loaded");
  chk_stop_low_no_load: assert property (
    rx_done && !rx_stop_first && !smart_card_select |-> !rx_buffer_load)
    else $error("load despite low stop bit");
endmodule

bind serial_status_flags serial_status_flags_sva i_chk (
  .clk_sys, .rst, .s_axi_wvalid, .tx_load, .rx_done, .rx_stop_first, .rx_parity_bad,
  .xfer_tx_write, .xfer_rx_read, .tx_mpb_out, .transmit_enable, .receive_enable,
  .smart_card_select, .rx_buffer_load, .transmit_request, .receive_request
);

// ### serial_far_end.sv
`timescale 1ns/1ps
module serial_far_end (
  input  wire logic clk_sys,
  input  wire logic tx_mpb_out,
  output logic      tx_load,
  output logic      tx_last_bit,
  output logic      rx_done,
  output logic      rx_stop_first,
  output logic      rx_parity_bad,
  output logic      rx_mpb_in,
  output logic      err_signal_low
);
  // ------------------------------------------------------------
  // Remote serial party
  // ------------------------------------------------------------
  logic sent_mpb;

  initial begin
    {tx_load, tx_last_bit, rx_done, err_signal_low} = 4'h0;
    {rx_stop_first, rx_parity_bad, rx_mpb_in, sent_mpb} = 4'h0;
  end

  // Character on the line carries the transmit multiproc bit
  always @(posedge clk_sys) if (tx_last_bit) sent_mpb <= tx_mpb_out;

  // One received character; only the first stop bit is offered
  task automatic frame(input logic stop, input logic par, input logic received_multiproc_bit);
    rx_stop_first <= stop;
    rx_parity_bad <= par;
    rx_mpb_in     <= received_multiproc_bit;
    rx_done       <= 1'b1;
    @(posedge clk_sys);
    rx_done       <= 1'b0;
    rx_stop_first <= ~stop;
    rx_parity_bad <= ~par;
    rx_mpb_in     <= ~received_multiproc_bit;
    @(posedge clk_sys);
  endtask

  // Kind 0 buffer moved, 1 last bit sent, 2 error signal low
  task automatic pulse(input int kind);
    tx_load        <= (kind == 0);
    tx_last_bit    <= (kind == 1);
    err_signal_low <= (kind == 2);
    @(posedge clk_sys);
    {tx_load, tx_last_bit, err_signal_low} <= 3'h0;
    @(posedge clk_sys);
  endtask
endmodule

// ### serial_status_flags_tb.sv
`timescale 1ns/1ps
module serial_status_flags_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk_sys, rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, tx_load, tx_last_bit, rx_done, rx_stop_first, rx_parity_bad;
  logic        rx_mpb_in, err_signal_low, xfer_tx_write, xfer_rx_read, tx_mpb_out, irq;
  logic        transmit_enable, receive_enable, smart_card_select, two_stop_bits;
  logic        rx_buffer_load, transmit_request, receive_request;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          mismatches, total_checks;
  logic [7:0]  case_ctl [5] = '{8'h03, 8'h03, 8'h0b, 8'h0b, 8'h07};
  logic [1:0]  case_sp  [5] = '{2'b00, 2'b11, 2'b10, 2'b00, 2'b00};
  logic [7:0]  case_exp [5] = '{8'h12, 8'h0a, 8'h42, 8'h12, 8'h42};

  serial_status_flags i_serial_status_flags (
    .clk_sys, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_load, .tx_last_bit, .rx_done, .rx_stop_first,
    .rx_parity_bad, .rx_mpb_in, .err_signal_low, .xfer_tx_write, .xfer_rx_read,
    .tx_mpb_out, .transmit_enable, .receive_enable, .smart_card_select, .two_stop_bits,
    .rx_buffer_load, .transmit_request, .receive_request, .irq
  );
  serial_far_end i_serial_far_end (
    .clk_sys, .tx_mpb_out, .tx_load, .tx_last_bit, .rx_done, .rx_stop_first,
    .rx_parity_bad, .rx_mpb_in, .err_signal_low
  );

  always #5 clk_sys = ~clk_sys;

  // ------------------------------------------------------------
  // Compare and bus tasks
  // ------------------------------------------------------------
  task automatic fail(input string msg);
    mismatches++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
  endtask
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("response %h expected %h", got, exp));
  endtask
  task automatic cmp_pin(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) fail($sformatf("%s is %b", what, got));
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [4:0] a, input logic [7:0] d,
                        input logic [1:0] er = serial_status_pkg::RESP_OKAY);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready))
               && n < 100);
    while (!s_axi_bvalid && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 100) fail("no write answer");
    cmp_resp(s_axi_bresp, er);
  endtask

  task automatic axi_rd(input logic [4:0] a, input logic [7:0] ed,
                        input logic [1:0] er = serial_status_pkg::RESP_OKAY);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!s_axi_arready && n < 100);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!s_axi_rvalid && n < 100);
    if (n >= 100) fail("no read answer");
    if (er === serial_status_pkg::RESP_OKAY) cmp_word(s_axi_rdata, {24'h0, ed});
    cmp_resp(s_axi_rresp, er);
  endtask

  task automatic st_rd(input logic [7:0] e);
    axi_rd({1'b0, serial_status_pkg::OFS_STATUS}, e);
  endtask
  task automatic st_wr(input logic [7:0] d);
    axi_wr({1'b0, serial_status_pkg::OFS_STATUS}, d);
  endtask
  task automatic ctl_wr(input logic [7:0] d);
    axi_wr({1'b0, serial_status_pkg::OFS_CONTROL}, d);
  endtask
  task automatic xfer(input logic tx);
    xfer_tx_write <= tx;
    xfer_rx_read  <= !tx;
    @(posedge clk_sys);
    {xfer_tx_write, xfer_rx_read} <= 2'b00;
    @(posedge clk_sys);
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    {rst, ce, s_axi_bready, s_axi_rready} = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, xfer_tx_write, xfer_rx_read} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
    s_axi_wstrb = 4'hf;
    mismatches = 0;
    total_checks = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    st_rd(serial_status_pkg::STATUS_RST);
    axi_rd({1'b0, serial_status_pkg::OFS_CONTROL}, 8'h00);
    axi_rd(5'h14, 8'h00, serial_status_pkg::RESP_SLVERR);
    axi_wr(5'h18, 8'hff, serial_status_pkg::RESP_SLVERR);
    st_wr(8'hff);
    st_rd(8'h85);
    i_serial_far_end.pulse(1);
    cmp_pin(i_serial_far_end.sent_mpb, 1'b1, "sent multiproc bit");
    st_wr(8'h00);
    st_rd(8'h84);
    $display("test reset and write masks done");
    ctl_wr(8'h03);
    st_rd(8'h84);
    st_wr(8'h00);
    st_rd(8'h00);
    cmp_pin(transmit_request, 1'b0, "transmit request");
    i_serial_far_end.pulse(0);
    st_rd(8'h80);
    i_serial_far_end.pulse(1);
    st_rd(8'h84);
    xfer(1'b1);
    st_rd(8'h00);
    i_serial_far_end.pulse(1);
    st_rd(8'h00);
    $display("test transmit flags done");
    axi_wr(serial_status_pkg::OFS_IRQ_CLRW, 8'h0f);
    axi_wr({1'b0, serial_status_pkg::OFS_IRQ_EN}, 8'h02);
    cmp_pin(irq, 1'b0, "irq idle");
    i_serial_far_end.frame(1'b1, 1'b0, 1'b1);
    st_rd(8'h42);
    axi_rd({1'b0, serial_status_pkg::OFS_IRQ_ST}, 8'h02);
    cmp_pin(irq, 1'b1, "irq raised");
    axi_wr({1'b0, serial_status_pkg::OFS_IRQ_EN}, 8'h00);
    i_serial_far_end.frame(1'b1, 1'b0, 1'b1);
    cmp_pin(irq, 1'b0, "irq masked");
    st_wr(8'h00);
    st_rd(8'h22);
    st_wr(8'h00);
    st_rd(8'h02);
    axi_wr(serial_status_pkg::OFS_IRQ_CLRW, 8'h0f);
    axi_rd({1'b0, serial_status_pkg::OFS_IRQ_ST}, 8'h00);
    $display("test receive and interrupt done");
    for (int i = 0; i < 5; i++) begin
      ctl_wr(case_ctl[i]);
      i_serial_far_end.frame(case_sp[i][1], case_sp[i][0], 1'b1);
      st_rd(case_exp[i]);
      st_wr(8'h00);
      st_rd(8'h02);
    end
    i_serial_far_end.pulse(2);
    st_wr(8'h00);
    st_rd(8'h12);
    st_wr(8'h00);
    st_rd(8'h02);
    $display("test error flags done");
    ctl_wr(8'h03);
    i_serial_far_end.frame(1'b1, 1'b0, 1'b0);
    st_rd(8'h40);
    ctl_wr(8'h01);
    i_serial_far_end.frame(1'b1, 1'b0, 1'b1);
    st_rd(8'h40);
    cmp_pin(receive_request, 1'b1, "receive request");
    xfer(1'b0);
    st_rd(8'h00);
    ctl_wr(8'h00);
    st_rd(8'h84);
    $display("test hold and disable done");
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail("watchdog expired");
    print_verdict();
  end
endmodule
